// file: hw/pio_filter.sv
`timescale 1ns/100ps
module pio_filter #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             port_tick,
  input  wire logic [WIDTH-1:0] filt_en,
  input  wire logic [WIDTH-1:0] raw_in,
  output logic      [WIDTH-1:0] filt_out
);

  typedef struct packed {
    logic [WIDTH-1:0] smp_a;
    logic [WIDTH-1:0] smp_b;
    logic [WIDTH-1:0] q;
  } pio_filt_s;

  pio_filt_s state;
  pio_filt_s next_state;

  always_comb begin
    next_state = state;
    for (int i = 0; i < int'(WIDTH); i++) begin
      if (!filt_en[i]) begin
        next_state.smp_a[i] = raw_in[i];
        next_state.smp_b[i] = raw_in[i];
        next_state.q[i]     = raw_in[i];
      end else if (port_tick) begin
        next_state.smp_a[i] = raw_in[i];
        next_state.smp_b[i] = state.smp_a[i];
        // level must hold over three ticks, 2 to 3 port clock periods
        if (raw_in[i] == state.smp_a[i] && state.smp_a[i] == state.smp_b[i]) begin
          next_state.q[i] = raw_in[i];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign filt_out = state.q;

endmodule : pio_filter

// file: hw/pio_pkg.sv
package pio_pkg;

  localparam int unsigned PIO_G0_PINS    = 8;
  localparam int unsigned PIO_G1_PINS    = 6;
  localparam int unsigned PIO_G2_PINS    = 2;
  localparam int unsigned PIO_DBG_PINS   = 3;
  localparam int unsigned PIO_NUM_FUNCS  = 4;
  localparam int unsigned PIO_SRC_COUNT  = 4;
  localparam int unsigned PIO_DIV_BITS   = 15;
  localparam int unsigned PIO_KRST_PINS  = 4;

  localparam logic [15:0] PIO_KEY_UNLOCK = 16'h0096;

  // key-reset pin select codes
  localparam logic [1:0]  PIO_KRST_OFF   = 2'h0;
  localparam logic [1:0]  PIO_KRST_P0_1  = 2'h1;
  localparam logic [1:0]  PIO_KRST_P0_2  = 2'h2;
  localparam logic [1:0]  PIO_KRST_P0_3  = 2'h3;

  typedef enum logic [1:0] {
    PIO_LOCKED   = 2'b01,
    PIO_UNLOCKED = 2'b10
  } pio_prot_e;

  typedef struct packed {
    logic [1:0] key_reset_pin_select;
    logic       run_in_debug;
    logic [3:0] filter_clk_divider;
    logic [1:0] filter_clk_source;
  } pio_clk_cfg_s;

  typedef struct packed {
    logic       pin_input_enable;
    logic       pin_output_enable;
    logic       pull_enable;
    logic       pull_up_select;
    logic       pin_filter_enable;
    logic       interrupt_edge_select;
    logic       periph_select;
    logic [1:0] periph_mux;
    logic       out_value;
  } pio_pin_cfg_s;

  localparam pio_clk_cfg_s PIO_CLK_CFG_RST = '0;
  localparam pio_pin_cfg_s PIO_PIN_CFG_RST = '0;

endpackage : pio_pkg

// file: hw/pio_port_block.sv
`timescale 1ns/100ps
module pio_port_block #(
  parameter int unsigned HAS_GROUP2 = 1,
  parameter int unsigned NPIN       = pio_pkg::PIO_G0_PINS + pio_pkg::PIO_G1_PINS
                                      + HAS_GROUP2 * pio_pkg::PIO_G2_PINS,
  parameter int unsigned NDBG       = pio_pkg::PIO_DBG_PINS,
  parameter int unsigned DIV_BITS   = pio_pkg::PIO_DIV_BITS
) (
  input  wire logic                                      sys_clk,
  input  wire logic                                      rst,
  input  wire logic                                      key_wr,
  input  wire logic [15:0]                               key_wdata,
  output logic                                           clk_cfg_unlocked,
  input  wire logic                                      clk_cfg_wr,
  input  wire pio_pkg::pio_clk_cfg_s                     clk_cfg_wdata,
  output pio_pkg::pio_clk_cfg_s                          clk_cfg,
  input  wire logic                                      pin_cfg_wr,
  input  wire logic [4:0]                                pin_cfg_idx,
  input  wire pio_pkg::pio_pin_cfg_s                     pin_cfg_wdata,
  output pio_pkg::pio_pin_cfg_s [NPIN-1:0]               pin_cfg,
  input  wire logic [pio_pkg::PIO_SRC_COUNT-1:0]         src_tick,
  input  wire logic [pio_pkg::PIO_SRC_COUNT-1:0]         source_stop_in_sleep,
  input  wire logic                                      sleep_mode,
  input  wire logic                                      debug_mode,
  output logic                                           port_filter_clock,
  input  wire logic [NPIN-1:0]                           pad_in,
  output logic      [NPIN-1:0]                           pad_out,
  output logic      [NPIN-1:0]                           pad_oe,
  output logic      [NPIN-1:0]                           pad_pull_up,
  output logic      [NPIN-1:0]                           pad_pull_down,
  output logic      [NPIN-1:0]                           gpio_in_data,
  output logic      [NPIN-1:0]                           pin_edge_event,
  input  wire logic [pio_pkg::PIO_NUM_FUNCS-1:0][NPIN-1:0] periph_out,
  input  wire logic [pio_pkg::PIO_NUM_FUNCS-1:0][NPIN-1:0] periph_oe,
  output logic      [NPIN-1:0]                           periph_in,
  output logic                                           key_reset_req,
  input  wire logic [NDBG-1:0]                           dbg_pad_in,
  output logic      [NDBG-1:0]                           dbg_pad_out,
  output logic      [NDBG-1:0]                           dbg_pad_oe,
  input  wire logic [NDBG-1:0]                           dbg_core_out,
  input  wire logic [NDBG-1:0]                           dbg_core_oe,
  output logic      [NDBG-1:0]                           dbg_core_in
);

  typedef struct packed {
    pio_pkg::pio_prot_e                 prot;
    pio_pkg::pio_clk_cfg_s              clk;
    pio_pkg::pio_pin_cfg_s [NPIN-1:0]   cfg;
    logic [DIV_BITS-1:0]                div_cnt;
    logic                               tick;
    logic [NPIN-1:0]                    prev_in;
    logic [NPIN-1:0]                    edge_evt;
    logic [NPIN-1:0]                    gpio_in;
    logic [NPIN-1:0]                    p_in;
    logic [NPIN-1:0]                    p_out;
    logic [NPIN-1:0]                    p_oe;
    logic [NPIN-1:0]                    pull_up;
    logic [NPIN-1:0]                    pull_dn;
    logic [NDBG-1:0]                    d_out;
    logic [NDBG-1:0]                    d_oe;
    logic [NDBG-1:0]                    d_in;
    logic                               krst;
  } pio_state_s;

  pio_state_s state;
  pio_state_s next_state;

  logic [NPIN+NDBG-1:0] sync_all;
  logic [NPIN-1:0]      pin_sync;
  logic [NPIN-1:0]      pin_filt;
  logic [NPIN-1:0]      filt_en_vec;
  logic                 src_sel_tick;
  logic                 stop_sleep;
  logic                 susp_dbg;
  logic                 clk_run;

  function automatic logic div_hit(input logic [DIV_BITS-1:0] cnt, input logic [3:0] div);
    logic [DIV_BITS:0] mask;
    mask = (DIV_BITS+1)'(({{DIV_BITS{1'b0}}, 1'b1} << div) - 1'b1);
    return (cnt & mask[DIV_BITS-1:0]) == mask[DIV_BITS-1:0];
  endfunction : div_hit

  function automatic logic [pio_pkg::PIO_KRST_PINS-1:0] krst_mask(input logic [1:0] sel);
    logic [pio_pkg::PIO_KRST_PINS-1:0] m;
    m = '0;
    unique case (sel)
      pio_pkg::PIO_KRST_OFF:  m = 4'h0;
      pio_pkg::PIO_KRST_P0_1: m = 4'h3;
      pio_pkg::PIO_KRST_P0_2: m = 4'h7;
      pio_pkg::PIO_KRST_P0_3: m = 4'hf;
    endcase
    return m;
  endfunction : krst_mask

  pio_sync3 #(
    .WIDTH    (NPIN + NDBG)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({dbg_pad_in, pad_in}),
    .sync_out (sync_all)
  );

  assign pin_sync = sync_all[NPIN-1:0];

  always_comb begin
    for (int i = 0; i < int'(NPIN); i++) begin
      filt_en_vec[i] = state.cfg[i].pin_filter_enable;
    end
  end

  pio_filter #(
    .WIDTH     (NPIN)
  ) u_filter (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .port_tick (state.tick),
    .filt_en   (filt_en_vec),
    .raw_in    (pin_sync),
    .filt_out  (pin_filt)
  );

  // port clock gating by sleep and debug
  assign src_sel_tick = src_tick[state.clk.filter_clk_source];
  assign stop_sleep   = sleep_mode & source_stop_in_sleep[state.clk.filter_clk_source];
  assign susp_dbg     = debug_mode & ~state.clk.run_in_debug;
  assign clk_run      = ~stop_sleep & ~susp_dbg;

  always_comb begin
    logic [NPIN-1:0]                   lvl;
    logic [NPIN-1:0]                   cond;
    logic [pio_pkg::PIO_KRST_PINS-1:0] kmask;
    lvl        = '0;
    cond       = '0;
    kmask      = '0;
    next_state = state;

    // system protection key
    if (key_wr) begin
      if (key_wdata == pio_pkg::PIO_KEY_UNLOCK) begin
        next_state.prot = pio_pkg::PIO_UNLOCKED;
      end else begin
        next_state.prot = pio_pkg::PIO_LOCKED;
      end
    end

    unique case (state.prot)
      pio_pkg::PIO_UNLOCKED: begin
        if (clk_cfg_wr) begin
          next_state.clk = clk_cfg_wdata;
        end
      end
      pio_pkg::PIO_LOCKED: begin
      end
      default: begin
        next_state.prot = pio_pkg::PIO_LOCKED;
      end
    endcase

    // pin configuration is open in every mode
    if (pin_cfg_wr && int'(pin_cfg_idx) < int'(NPIN)) begin
      next_state.cfg[pin_cfg_idx] = pin_cfg_wdata;
    end

    // divided port filter clock
    next_state.tick = 1'b0;
    if (clk_run && src_sel_tick) begin
      next_state.div_cnt = DIV_BITS'(state.div_cnt + 1'b1);
      next_state.tick    = div_hit(state.div_cnt, state.clk.filter_clk_divider);
    end

    for (int i = 0; i < int'(NPIN); i++) begin
      if (!state.cfg[i].pin_filter_enable) begin
        lvl[i] = pin_sync[i];
      end else if (stop_sleep) begin
        lvl[i] = pin_sync[i];
      end else if (susp_dbg) begin
        lvl[i] = 1'b0;
      end else begin
        lvl[i] = pin_filt[i];
      end
      cond[i] = lvl[i] & state.cfg[i].pin_input_enable;

      // peripheral inputs see the level only while selected
      next_state.p_in[i]    = lvl[i] & state.cfg[i].periph_select;
      next_state.gpio_in[i] = cond[i] & ~state.cfg[i].periph_select;

      if (state.cfg[i].periph_select) begin
        next_state.p_out[i] = periph_out[state.cfg[i].periph_mux][i];
        next_state.p_oe[i]  = periph_oe[state.cfg[i].periph_mux][i];
      end else begin
        next_state.p_out[i] = state.cfg[i].out_value;
        next_state.p_oe[i]  = state.cfg[i].pin_output_enable;
      end

      // pulls act only while the driver is off
      next_state.pull_up[i] = state.cfg[i].pull_enable & state.cfg[i].pull_up_select
                              & ~next_state.p_oe[i];
      next_state.pull_dn[i] = state.cfg[i].pull_enable & ~state.cfg[i].pull_up_select
                              & ~next_state.p_oe[i];

      // edge events on GPIO-selected pins only
      next_state.prev_in[i] = cond[i];
      if (state.cfg[i].periph_select) begin
        next_state.edge_evt[i] = 1'b0;
      end else if (state.cfg[i].interrupt_edge_select) begin
        next_state.edge_evt[i] = state.prev_in[i] & ~cond[i];
      end else begin
        next_state.edge_evt[i] = ~state.prev_in[i] & cond[i];
      end
    end

    // key-entry reset on low group 0 pins
    kmask = krst_mask(state.clk.key_reset_pin_select);
    next_state.krst = (kmask != '0) && ((cond[pio_pkg::PIO_KRST_PINS-1:0] & kmask) == '0);

    // debug group keeps the debug function
    next_state.d_out = dbg_core_out;
    next_state.d_oe  = dbg_core_oe;
    next_state.d_in  = sync_all[NPIN+NDBG-1:NPIN];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state      <= '0;
      state.prot <= pio_pkg::PIO_LOCKED;
      state.clk  <= pio_pkg::PIO_CLK_CFG_RST;
      state.cfg  <= {NPIN{pio_pkg::PIO_PIN_CFG_RST}};
    end else begin
      state      <= next_state;
    end
  end

  assign clk_cfg_unlocked  = (state.prot == pio_pkg::PIO_UNLOCKED);
  assign clk_cfg           = state.clk;
  assign pin_cfg           = state.cfg;
  assign port_filter_clock = state.tick;
  assign pad_out           = state.p_out;
  assign pad_oe            = state.p_oe;
  assign pad_pull_up       = state.pull_up;
  assign pad_pull_down     = state.pull_dn;
  assign gpio_in_data      = state.gpio_in;
  assign pin_edge_event    = state.edge_evt;
  assign periph_in         = state.p_in;
  assign key_reset_req     = state.krst;
  assign dbg_pad_out       = state.d_out;
  assign dbg_pad_oe        = state.d_oe;
  assign dbg_core_in       = state.d_in;

  // group sizes fixed by the package, group 2 optional
  localparam int unsigned GROUP_CHECK = (NPIN >= pio_pkg::PIO_G0_PINS + pio_pkg::PIO_G1_PINS) ? 1 : 0;

endmodule : pio_port_block

// file: hw/pio_sync3.sv
`timescale 1ns/100ps
module pio_sync3 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } pio_sync_s;

  pio_sync_s state;
  pio_sync_s next_state;

  always_comb begin
    next_state    = state;
    next_state.s1 = async_in;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
    for (int i = 0; i < int'(WIDTH); i++) begin
      // a change counts once stages two and three agree
      if (state.s2[i] == state.s3[i]) begin
        next_state.q[i] = state.s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.q;

endmodule : pio_sync3

// file: sim/pio_pin_partner.sv
`timescale 1ns/100ps
module pio_pin_partner #(
  parameter int unsigned N = 16
) (
  input  wire logic         sys_clk,
  input  wire logic [N-1:0] pad_out,
  input  wire logic [N-1:0] pad_oe,
  input  wire logic [N-1:0] pad_pull_up,
  input  wire logic [N-1:0] pad_pull_down,
  input  wire logic [N-1:0] board_en,
  input  wire logic [N-1:0] board_lvl,
  output logic      [N-1:0] pad_in
);
  logic [N-1:0] drift;
  initial drift = '0;
  // floating pin wanders every cycle
  always @(posedge sys_clk) drift <= ~drift;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (board_en[i]) pad_in[i] = board_lvl[i];
      else if (pad_pull_up[i]) pad_in[i] = 1'b1;
      else if (pad_pull_down[i]) pad_in[i] = 1'b0;
      else pad_in[i] = drift[i];
    end
  end
endmodule : pio_pin_partner

// file: sim/pio_port_block_checker.sv
`timescale 1ns/100ps
module pio_port_block_checker #(
  parameter int unsigned NPIN = 16,
  parameter int unsigned NDBG = 3
) (
  input wire logic                         sys_clk,
  input wire logic                         rst,
  input wire logic                         key_wr,
  input wire logic [15:0]                  key_wdata,
  input wire logic                         clk_cfg_unlocked,
  input wire logic                         clk_cfg_wr,
  input wire pio_pkg::pio_clk_cfg_s        clk_cfg_wdata,
  input wire pio_pkg::pio_clk_cfg_s        clk_cfg,
  input wire logic                         pin_cfg_wr,
  input wire logic [4:0]                   pin_cfg_idx,
  input wire pio_pkg::pio_pin_cfg_s        pin_cfg_wdata,
  input wire pio_pkg::pio_pin_cfg_s [NPIN-1:0] pin_cfg,
  input wire logic [3:0]                   source_stop_in_sleep,
  input wire logic                         sleep_mode,
  input wire logic                         debug_mode,
  input wire logic                         port_filter_clock,
  input wire logic [NPIN-1:0]              pad_oe,
  input wire logic [NPIN-1:0]              pad_pull_up,
  input wire logic [NPIN-1:0]              pad_pull_down,
  input wire logic [NPIN-1:0]              gpio_in_data,
  input wire logic [NPIN-1:0]              pin_edge_event,
  input wire logic                         key_reset_req,
  input wire logic [NDBG-1:0]              dbg_pad_out,
  input wire logic [NDBG-1:0]              dbg_pad_oe,
  input wire logic [NDBG-1:0]              dbg_core_out,
  input wire logic [NDBG-1:0]              dbg_core_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_UNLOCK: assert property (key_wr && key_wdata == 16'h0096 |=> clk_cfg_unlocked)
    else $error("unlock key ignored");
  AST_RELOCK: assert property (key_wr && key_wdata != 16'h0096 |=> !clk_cfg_unlocked)
    else $error("other key left settings open");
  AST_CFG_REFUSED: assert property (clk_cfg_wr && !clk_cfg_unlocked |=> $stable(clk_cfg))
    else $error("locked clock settings changed");
  AST_CFG_TAKEN: assert property (clk_cfg_wr && clk_cfg_unlocked |=> clk_cfg == $past(clk_cfg_wdata))
    else $error("clock settings not taken");
  AST_PIN_TAKEN: assert property (pin_cfg_wr && pin_cfg_idx < NPIN
    |=> pin_cfg[$past(pin_cfg_idx)] == $past(pin_cfg_wdata))
    else $error("pin settings not taken");
  AST_PULL_VS_DRIVE: assert property ((((pad_pull_up | pad_pull_down) & pad_oe) | (pad_pull_up & pad_pull_down)) == '0)
    else $error("pull clashes with driver");
  AST_RESET_HIZ: assert property ($fell(rst) |-> pad_oe == '0 && (pad_pull_up | pad_pull_down) == '0 && !clk_cfg_unlocked)
    else $error("pins not idle after reset");
  AST_DBG_FOLLOW: assert property (!$past(rst) |-> dbg_pad_out == $past(dbg_core_out) && dbg_pad_oe == $past(dbg_core_oe))
    else $error("debug pins do not follow core");
  AST_DEBUG_HALT: assert property ((debug_mode && !clk_cfg.run_in_debug) [*2] |-> !port_filter_clock)
    else $error("port clock ran in debug");
  AST_SLEEP_HALT: assert property ((sleep_mode && source_stop_in_sleep[clk_cfg.filter_clk_source]) [*2]
    |-> !port_filter_clock)
    else $error("port clock ran in sleep");
  AST_INPUT_BLOCKED: assert property ((!pin_cfg[0].pin_input_enable) [*3] |-> !gpio_in_data[0])
    else $error("disabled input reached logic");
  AST_DEBUG_FILTER_OFF: assert property ((debug_mode && !clk_cfg.run_in_debug && pin_cfg[1].pin_filter_enable) [*3]
    |-> !gpio_in_data[1])
    else $error("filtered input alive in debug");
  cover property (key_wr && key_wdata == 16'h0096);
  cover property (pin_edge_event[2]);
  cover property (key_reset_req);
  cover property (debug_mode && port_filter_clock);
endmodule : pio_port_block_checker

bind pio_port_block pio_port_block_checker #(.NPIN(NPIN), .NDBG(NDBG)) u_checker (
  .sys_clk(sys_clk), .rst(rst), .key_wr(key_wr), .key_wdata(key_wdata), .clk_cfg_unlocked(clk_cfg_unlocked),
  .clk_cfg_wr(clk_cfg_wr), .clk_cfg_wdata(clk_cfg_wdata), .clk_cfg(clk_cfg), .pin_cfg_wr(pin_cfg_wr),
  .pin_cfg_idx(pin_cfg_idx), .pin_cfg_wdata(pin_cfg_wdata), .pin_cfg(pin_cfg),
  .source_stop_in_sleep(source_stop_in_sleep), .sleep_mode(sleep_mode), .debug_mode(debug_mode),
  .port_filter_clock(port_filter_clock), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
  .pad_pull_down(pad_pull_down), .gpio_in_data(gpio_in_data), .pin_edge_event(pin_edge_event),
  .key_reset_req(key_reset_req), .dbg_pad_out(dbg_pad_out), .dbg_pad_oe(dbg_pad_oe),
  .dbg_core_out(dbg_core_out), .dbg_core_oe(dbg_core_oe));

// file: sim/pio_port_block_tb.sv
`timescale 1ns/100ps
module pio_port_block_tb;
  localparam int NP = 16;
  // rows: pin settings, then expected oe, out, pull-up, pull-down
  localparam logic [13:0] ROWS [6] = '{14'h0000, 14'h0c02, 14'h0801, 14'h101c, 14'h1c08, 14'h2c02};
  logic sys_clk, rst, key_wr, clk_cfg_wr, pin_cfg_wr, sleep_mode, debug_mode, clk_cfg_unlocked;
  logic port_filter_clock, key_reset_req;
  logic [15:0] key_wdata;
  logic [4:0] pin_cfg_idx;
  logic [3:0] src_tick, source_stop_in_sleep;
  pio_pkg::pio_clk_cfg_s clk_cfg_wdata, clk_cfg, cc;
  pio_pkg::pio_pin_cfg_s pin_cfg_wdata;
  pio_pkg::pio_pin_cfg_s [NP-1:0] pin_cfg;
  logic [NP-1:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down, gpio_in_data, pin_edge_event, periph_in;
  logic [NP-1:0] board_en, board_lvl;
  logic [3:0][NP-1:0] periph_out, periph_oe;
  logic [2:0] dbg_pad_in, dbg_pad_out, dbg_pad_oe, dbg_core_out, dbg_core_oe, dbg_core_in;
  int errors, checks_done, n;

  pio_port_block DUT (.sys_clk(sys_clk), .rst(rst), .key_wr(key_wr), .key_wdata(key_wdata),
    .clk_cfg_unlocked(clk_cfg_unlocked), .clk_cfg_wr(clk_cfg_wr), .clk_cfg_wdata(clk_cfg_wdata),
    .clk_cfg(clk_cfg), .pin_cfg_wr(pin_cfg_wr), .pin_cfg_idx(pin_cfg_idx), .pin_cfg_wdata(pin_cfg_wdata),
    .pin_cfg(pin_cfg), .src_tick(src_tick), .source_stop_in_sleep(source_stop_in_sleep),
    .sleep_mode(sleep_mode), .debug_mode(debug_mode), .port_filter_clock(port_filter_clock),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .pad_pull_down(pad_pull_down), .gpio_in_data(gpio_in_data), .pin_edge_event(pin_edge_event),
    .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in), .key_reset_req(key_reset_req),
    .dbg_pad_in(dbg_pad_in), .dbg_pad_out(dbg_pad_out), .dbg_pad_oe(dbg_pad_oe),
    .dbg_core_out(dbg_core_out), .dbg_core_oe(dbg_core_oe), .dbg_core_in(dbg_core_in));
  pio_pin_partner #(.N(NP)) PINS (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .board_en(board_en), .board_lvl(board_lvl),
    .pad_in(pad_in));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic wr_pin(input int idx, input pio_pkg::pio_pin_cfg_s c);
    @(negedge sys_clk);
    pin_cfg_idx = 5'(idx);
    pin_cfg_wdata = c;
    pin_cfg_wr = 1'b1;
    @(negedge sys_clk);
    pin_cfg_wr = 1'b0;
  endtask : wr_pin

  task automatic wr_key(input logic [15:0] v);
    @(negedge sys_clk);
    key_wdata = v;
    key_wr = 1'b1;
    @(negedge sys_clk);
    key_wr = 1'b0;
  endtask : wr_key

  task automatic wr_clk(input pio_pkg::pio_clk_cfg_s c);
    @(negedge sys_clk);
    clk_cfg_wdata = c;
    clk_cfg_wr = 1'b1;
    @(negedge sys_clk);
    clk_cfg_wr = 1'b0;
    @(negedge sys_clk);
  endtask : wr_clk

  task automatic wait_in(input int idx, input logic v);
    for (int i = 0; i < 80 && gpio_in_data[idx] !== v; i++) @(negedge sys_clk);
    chk(gpio_in_data[idx], v);
  endtask : wait_in

  // counts port ticks (sel 0) or pin 2 edge events (sel 1)
  task automatic cnt(input int cyc, input int sel, output int c);
    c = 0;
    repeat (2) @(negedge sys_clk);
    repeat (cyc) begin
      @(negedge sys_clk);
      c += (sel == 0) ? int'(port_filter_clock) : int'(pin_edge_event[2]);
    end
  endtask : cnt

  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    close_out();
  end

  initial begin
    {rst, key_wr, clk_cfg_wr, pin_cfg_wr, sleep_mode, debug_mode} = 6'h20;
    key_wdata = '0; pin_cfg_idx = '0; clk_cfg_wdata = '0; pin_cfg_wdata = '0; cc = '0;
    src_tick = 4'h1; source_stop_in_sleep = '0; periph_out = '0; periph_oe = '0;
    board_en = 16'h0047; board_lvl = 16'h0040;
    dbg_pad_in = 3'h6; dbg_core_out = 3'h3; dbg_core_oe = 3'h5; errors = 0; checks_done = 0;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    chk(pad_oe | pad_pull_up | pad_pull_down, '0);
    chk({clk_cfg_unlocked, clk_cfg}, '0);
    repeat (6) @(negedge sys_clk);
    chk({dbg_pad_oe, dbg_pad_out, dbg_core_in}, {3'h5, 3'h3, 3'h6});
    for (int i = 0; i < 6; i++) begin
      wr_pin(4, ROWS[i][13:4]);
      repeat (2) @(negedge sys_clk);
      chk({pad_oe[4], pad_out[4], pad_pull_up[4], pad_pull_down[4]}, ROWS[i][3:0]);
    end
    cc.filter_clk_divider = 4'h2;
    wr_clk(cc);
    chk(clk_cfg, '0);
    wr_key(16'h0096);
    chk(clk_cfg_unlocked, 1'b1);
    for (int d = 3; d >= 1; d -= 2) begin
      cc.filter_clk_divider = 4'(d);
      wr_clk(cc);
      chk(clk_cfg, cc);
      cnt(64, 0, n);
      chk(n, 64 >> d);
    end
    cc.filter_clk_source = 2'h1;
    wr_clk(cc);
    cnt(32, 0, n);
    chk(n, 0);
    cc.filter_clk_source = 2'h0;
    wr_clk(cc);
    wr_pin(1, 10'h220);
    wait_in(1, 1'b0);
    board_lvl[1] = 1'b1;
    repeat (2) @(negedge sys_clk);
    board_lvl[1] = 1'b0;
    cnt(20, 0, n);
    chk(gpio_in_data[1], 1'b0);
    board_lvl[1] = 1'b1;
    wait_in(1, 1'b1);
    debug_mode = 1'b1;
    wait_in(1, 1'b0);
    cnt(16, 0, n);
    chk(n, 0);
    wr_pin(5, 10'h200);
    chk(pin_cfg[5], 10'h200);
    debug_mode = 1'b0;
    wait_in(1, 1'b1);
    cc.run_in_debug = 1'b1;
    wr_clk(cc);
    debug_mode = 1'b1;
    cnt(16, 0, n);
    chk({n[7:0], gpio_in_data[1]}, {8'h08, 1'b1});
    debug_mode = 1'b0;
    source_stop_in_sleep = 4'h1;
    sleep_mode = 1'b1;
    cnt(16, 0, n);
    chk(n, 0);
    board_lvl[1] = 1'b0;
    wait_in(1, 1'b0);
    source_stop_in_sleep = 4'h0;
    cnt(16, 0, n);
    chk(n, 8);
    board_lvl[1] = 1'b1;
    wait_in(1, 1'b1);
    sleep_mode = 1'b0;
    wr_pin(2, 10'h200);
    wait_in(2, 1'b0);
    for (int e = 0; e < 2; e++) begin
      wr_pin(2, e ? 10'h210 : 10'h200);
      for (int v = 1; v >= 0; v--) begin
        board_lvl[2] = v[0];
        cnt(20, 1, n);
        chk(n, int'(v != e));
      end
    end
    for (int k = 0; k < 4; k++) begin
      periph_out = '0;
      periph_oe = '0;
      periph_out[k][3] = 1'b1;
      periph_oe[k][3] = 1'b1;
      wr_pin(3, {7'h01, 2'(k), 1'b0});
      repeat (2) @(negedge sys_clk);
      chk({pad_oe[3], pad_out[3], gpio_in_data[3]}, 3'h6);
    end
    chk(periph_in[3], 1'b1);
    chk(gpio_in_data[7:6], 2'h0);
    wr_pin(0, 10'h200);
    cc.key_reset_pin_select = 2'h1;
    wr_clk(cc);
    board_lvl[1] = 1'b0;
    wait_in(1, 1'b0);
    repeat (2) @(negedge sys_clk);
    chk(key_reset_req, 1'b1);
    board_lvl[0] = 1'b1;
    wait_in(0, 1'b1);
    repeat (2) @(negedge sys_clk);
    chk(key_reset_req, 1'b0);
    wr_key(16'h1234);
    chk(clk_cfg_unlocked, 1'b0);
    wr_clk('0);
    chk(clk_cfg, cc);
    close_out();
  end
endmodule : pio_port_block_tb
